/* core/pdc_pkg.sv */
// Constants for the PLL divider configuration register bank
package pdc_pkg;

	// Widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int LS_W   = 20;
	localparam int HS_W   = 3;
	localparam int RAT_W  = 21;
	localparam int HSR_W  = 4;

	// Register offsets
	localparam logic [7:0] OUT_HS_DIV_OFF    = 8'h19;
	localparam logic [7:0] OUT1_UPPER_OFF    = 8'h1f;
	localparam logic [7:0] OUT1_MID_OFF      = 8'h20;
	localparam logic [7:0] OUT1_LOW_OFF      = 8'h21;
	localparam logic [7:0] OUT2_UPPER_OFF    = 8'h22;
	localparam logic [7:0] OUT2_MID_OFF      = 8'h23;
	localparam logic [7:0] OUT2_LOW_OFF      = 8'h24;
	localparam logic [7:0] FB_HS_UPPER_OFF   = 8'h28;
	localparam logic [7:0] FB_LS_MID_OFF     = 8'h29;
	localparam logic [7:0] FB_LS_LOW_OFF     = 8'h2a;

	// Writable bit masks; cleared bits are reserved and read as zero
	localparam logic [7:0] UPPER_NIB_MASK    = 8'h0f;
	localparam logic [7:0] FULL_BYTE_MASK    = 8'hff;
	localparam logic [7:0] FB_HS_UPPER_MASK  = 8'hef;
	localparam logic [7:0] OUT_HS_MASK       = 8'he0;

	// Field positions
	localparam int HS_FIELD_LSB = 5;
	localparam int NIB_MSB      = 3;

	// Reset values
	localparam logic [7:0] OUT_HS_DIV_RST    = 8'h20;
	localparam logic [7:0] OUT_UPPER_RST     = 8'h00;
	localparam logic [7:0] OUT_MID_RST       = 8'h00;
	localparam logic [7:0] OUT_LOW_RST       = 8'h31;
	localparam logic [7:0] FB_HS_UPPER_RST   = 8'hc0;
	localparam logic [7:0] FB_LS_MID_RST     = 8'h00;
	localparam logic [7:0] FB_LS_LOW_RST     = 8'hf9;
	localparam logic [7:0] READ_ZERO         = 8'h00;

	// Ratio encoding constants
	localparam logic [3:0]  HS_RATIO_BASE    = 4'h4;
	localparam logic [20:0] LS_RATIO_ONE     = 21'h0_0001;
	localparam logic [19:0] LS_CODE_ZERO     = 20'h0_0000;

endpackage

/* core/pdc_regs.sv */
// Divider configuration register bank with decoded divider values and ratios

// Summary of operation
// - Output 1 low-speed divider is 20 bits over three registers: nibble, mid, low.
// - Output 2 low-speed divider is a separate 20-bit field, same three-register split.
// - Output divider code zero divides by one, odd code v divides by v+1.
// - Feedback high-speed divider in bits 7:5, codes 0..7 give ratios 4..11.
// - Feedback low-speed divider is 20 bits, upper nibble shares the high-speed register.
// - Feedback low-speed code must be odd, dividing by v+1; even codes flagged.
// - Reset loads output low bytes 0x31, feedback shared register 0xC0, output high-speed register 0x20, feedback low 0xF9, others zero.
// - Feedback low byte sits after the mid byte, resetting to 0xF9.
// - Output dividers are fed by a shared output high-speed divider, ratios 4..11.
module pdc_regs
(
	input  wire logic                          CLK,
	input  wire logic                          SYS_RST,
	input  wire logic [pdc_pkg::ADDR_W-1:0]    REG_ADDR,
	input  wire logic                          REG_WR,
	input  wire logic                          REG_RD,
	input  wire logic [pdc_pkg::DATA_W-1:0]    REG_WDATA,
	output logic      [pdc_pkg::DATA_W-1:0]    REG_RDATA,
	output logic                               REG_RVALID,
	output logic      [pdc_pkg::LS_W-1:0]      OUT1_LS_DIV,
	output logic      [pdc_pkg::LS_W-1:0]      OUT2_LS_DIV,
	output logic      [pdc_pkg::RAT_W-1:0]     OUT1_RATIO,
	output logic      [pdc_pkg::RAT_W-1:0]     OUT2_RATIO,
	output logic      [pdc_pkg::HS_W-1:0]      OUT_HS_DIV,
	output logic      [pdc_pkg::HSR_W-1:0]     OUT_HS_RATIO,
	output logic      [pdc_pkg::HS_W-1:0]      FB_HS_DIV,
	output logic      [pdc_pkg::HSR_W-1:0]     FB_HS_RATIO,
	output logic      [pdc_pkg::LS_W-1:0]      FB_LS_DIV,
	output logic      [pdc_pkg::RAT_W-1:0]     FB_LS_RATIO,
	output logic                               OUT1_CFG_ERR,
	output logic                               OUT2_CFG_ERR,
	output logic                               FB_CFG_ERR
);

	// Masked write: reserved bits always forced to zero
	function automatic logic [7:0] pdc_upd(input logic [7:0] cur, input logic hit,
		input logic [7:0] wdata, input logic [7:0] mask);
		pdc_upd = hit ? (wdata & mask) : cur;
	endfunction

	// Low-speed ratio: zero divides by one, otherwise code plus one
	function automatic logic [20:0] pdc_ls_ratio(input logic [19:0] code);
		pdc_ls_ratio = (code == pdc_pkg::LS_CODE_ZERO) ? pdc_pkg::LS_RATIO_ONE : {1'b0, code} + 21'h0_0001;
	endfunction

	// High-speed ratio: code plus base of four
	function automatic logic [3:0] pdc_hs_ratio(input logic [2:0] code);
		pdc_hs_ratio = {1'b0, code} + pdc_pkg::HS_RATIO_BASE;
	endfunction

	logic [7:0]  out_hs_reg;
	logic [7:0]  out1_up_reg;
	logic [7:0]  out1_mid_reg;
	logic [7:0]  out1_low_reg;
	logic [7:0]  out2_up_reg;
	logic [7:0]  out2_mid_reg;
	logic [7:0]  out2_low_reg;
	logic [7:0]  fb_up_reg;
	logic [7:0]  fb_mid_reg;
	logic [7:0]  fb_low_reg;
	logic [7:0]  out_hs_next;
	logic [7:0]  out1_up_next;
	logic [7:0]  out1_mid_next;
	logic [7:0]  out1_low_next;
	logic [7:0]  out2_up_next;
	logic [7:0]  out2_mid_next;
	logic [7:0]  out2_low_next;
	logic [7:0]  fb_up_next;
	logic [7:0]  fb_mid_next;
	logic [7:0]  fb_low_next;
	logic        hit_out_hs;
	logic        hit_out1_up;
	logic        hit_out1_mid;
	logic        hit_out1_low;
	logic        hit_out2_up;
	logic        hit_out2_mid;
	logic        hit_out2_low;
	logic        hit_fb_up;
	logic        hit_fb_mid;
	logic        hit_fb_low;
	logic [7:0]  rd_mux;
	logic [19:0] out1_code;
	logic [19:0] out2_code;
	logic [19:0] fb_code;
	logic [2:0]  out_hs_code;
	logic [2:0]  fb_hs_code;
	logic [7:0]  rsv_keep_mask;

	// Address decode
	assign hit_out_hs   = (REG_ADDR == pdc_pkg::OUT_HS_DIV_OFF);
	assign hit_out1_up  = (REG_ADDR == pdc_pkg::OUT1_UPPER_OFF);
	assign hit_out1_mid = (REG_ADDR == pdc_pkg::OUT1_MID_OFF);
	assign hit_out1_low = (REG_ADDR == pdc_pkg::OUT1_LOW_OFF);
	assign hit_out2_up  = (REG_ADDR == pdc_pkg::OUT2_UPPER_OFF);
	assign hit_out2_mid = (REG_ADDR == pdc_pkg::OUT2_MID_OFF);
	assign hit_out2_low = (REG_ADDR == pdc_pkg::OUT2_LOW_OFF);
	assign hit_fb_up    = (REG_ADDR == pdc_pkg::FB_HS_UPPER_OFF);
	assign hit_fb_mid   = (REG_ADDR == pdc_pkg::FB_LS_MID_OFF);
	assign hit_fb_low   = (REG_ADDR == pdc_pkg::FB_LS_LOW_OFF);

	// Next values; masks keep reserved bits at zero
	assign out_hs_next   = pdc_upd(out_hs_reg, REG_WR & hit_out_hs, REG_WDATA, pdc_pkg::OUT_HS_MASK);
	assign out1_up_next  = pdc_upd(out1_up_reg, REG_WR & hit_out1_up, REG_WDATA, pdc_pkg::UPPER_NIB_MASK);
	assign out1_mid_next = pdc_upd(out1_mid_reg, REG_WR & hit_out1_mid, REG_WDATA, pdc_pkg::FULL_BYTE_MASK);
	assign out1_low_next = pdc_upd(out1_low_reg, REG_WR & hit_out1_low, REG_WDATA, pdc_pkg::FULL_BYTE_MASK);
	assign out2_up_next  = pdc_upd(out2_up_reg, REG_WR & hit_out2_up, REG_WDATA, pdc_pkg::UPPER_NIB_MASK);
	assign out2_mid_next = pdc_upd(out2_mid_reg, REG_WR & hit_out2_mid, REG_WDATA, pdc_pkg::FULL_BYTE_MASK);
	assign out2_low_next = pdc_upd(out2_low_reg, REG_WR & hit_out2_low, REG_WDATA, pdc_pkg::FULL_BYTE_MASK);
	assign fb_up_next    = pdc_upd(fb_up_reg, REG_WR & hit_fb_up, REG_WDATA, pdc_pkg::FB_HS_UPPER_MASK);
	assign fb_mid_next   = pdc_upd(fb_mid_reg, REG_WR & hit_fb_mid, REG_WDATA, pdc_pkg::FULL_BYTE_MASK);
	assign fb_low_next   = pdc_upd(fb_low_reg, REG_WR & hit_fb_low, REG_WDATA, pdc_pkg::FULL_BYTE_MASK);

	// Register storage with documented reset values
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			out_hs_reg   <= pdc_pkg::OUT_HS_DIV_RST;
			out1_up_reg  <= pdc_pkg::OUT_UPPER_RST;
			out1_mid_reg <= pdc_pkg::OUT_MID_RST;
			out1_low_reg <= pdc_pkg::OUT_LOW_RST;
			out2_up_reg  <= pdc_pkg::OUT_UPPER_RST;
			out2_mid_reg <= pdc_pkg::OUT_MID_RST;
			out2_low_reg <= pdc_pkg::OUT_LOW_RST;
			fb_up_reg    <= pdc_pkg::FB_HS_UPPER_RST;
			fb_mid_reg   <= pdc_pkg::FB_LS_MID_RST;
			fb_low_reg   <= pdc_pkg::FB_LS_LOW_RST;
		end
		else
		begin
			out_hs_reg   <= out_hs_next;
			out1_up_reg  <= out1_up_next;
			out1_mid_reg <= out1_mid_next;
			out1_low_reg <= out1_low_next;
			out2_up_reg  <= out2_up_next;
			out2_mid_reg <= out2_mid_next;
			out2_low_reg <= out2_low_next;
			fb_up_reg    <= fb_up_next;
			fb_mid_reg   <= fb_mid_next;
			fb_low_reg   <= fb_low_next;
		end
	end

	// Field assembly from the byte registers
	assign out1_code   = {out1_up_reg[pdc_pkg::NIB_MSB:0], out1_mid_reg, out1_low_reg};
	assign out2_code   = {out2_up_reg[pdc_pkg::NIB_MSB:0], out2_mid_reg, out2_low_reg};
	assign fb_code     = {fb_up_reg[pdc_pkg::NIB_MSB:0], fb_mid_reg, fb_low_reg};
	assign fb_hs_code  = fb_up_reg[pdc_pkg::HS_FIELD_LSB +: pdc_pkg::HS_W];
	assign out_hs_code = out_hs_reg[pdc_pkg::HS_FIELD_LSB +: pdc_pkg::HS_W];

	// Read mux; unmapped addresses read as zero
	assign rd_mux = ({8{hit_out_hs}} & out_hs_reg) | ({8{hit_out1_up}} & out1_up_reg)
		| ({8{hit_out1_mid}} & out1_mid_reg) | ({8{hit_out1_low}} & out1_low_reg)
		| ({8{hit_out2_up}} & out2_up_reg) | ({8{hit_out2_mid}} & out2_mid_reg)
		| ({8{hit_out2_low}} & out2_low_reg) | ({8{hit_fb_up}} & fb_up_reg)
		| ({8{hit_fb_mid}} & fb_mid_reg) | ({8{hit_fb_low}} & fb_low_reg);

	// Writable bits of the addressed register with reserved bits; only the checker reads it
	assign rsv_keep_mask = hit_out_hs ? pdc_pkg::OUT_HS_MASK
		: (hit_fb_up ? pdc_pkg::FB_HS_UPPER_MASK : pdc_pkg::UPPER_NIB_MASK);

	// Read port: data one cycle after the strobe
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			REG_RDATA  <= pdc_pkg::READ_ZERO;
			REG_RVALID <= 1'b0;
		end
		else
		begin
			REG_RDATA  <= REG_RD ? rd_mux : pdc_pkg::READ_ZERO;
			REG_RVALID <= REG_RD;
		end
	end

	// Divider values out; registered so the analog side sees clean levels
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			OUT1_LS_DIV <= '0;
			OUT2_LS_DIV <= '0;
			FB_LS_DIV   <= '0;
			FB_HS_DIV   <= '0;
			OUT_HS_DIV  <= '0;
		end
		else
		begin
			OUT1_LS_DIV <= out1_code;
			OUT2_LS_DIV <= out2_code;
			FB_LS_DIV   <= fb_code;
			FB_HS_DIV   <= fb_hs_code;
			OUT_HS_DIV  <= out_hs_code;
		end
	end

	// Ratios and illegal-code flags; a bad code is kept, only flagged
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			OUT1_RATIO   <= pdc_pkg::LS_RATIO_ONE;
			OUT2_RATIO   <= pdc_pkg::LS_RATIO_ONE;
			FB_LS_RATIO  <= pdc_pkg::LS_RATIO_ONE;
			FB_HS_RATIO  <= pdc_pkg::HS_RATIO_BASE;
			OUT_HS_RATIO <= pdc_pkg::HS_RATIO_BASE;
			OUT1_CFG_ERR <= 1'b0;
			OUT2_CFG_ERR <= 1'b0;
			FB_CFG_ERR   <= 1'b0;
		end
		else
		begin
			OUT1_RATIO   <= pdc_ls_ratio(out1_code);
			OUT2_RATIO   <= pdc_ls_ratio(out2_code);
			FB_LS_RATIO  <= {1'b0, fb_code} + 21'h0_0001;
			FB_HS_RATIO  <= pdc_hs_ratio(fb_hs_code);
			OUT_HS_RATIO <= pdc_hs_ratio(out_hs_code);
			OUT1_CFG_ERR <= (out1_code != pdc_pkg::LS_CODE_ZERO) & ~out1_code[0];
			OUT2_CFG_ERR <= (out2_code != pdc_pkg::LS_CODE_ZERO) & ~out2_code[0];
			FB_CFG_ERR   <= ~fb_code[0];
		end
	end

	out1_assembly_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		!$past(SYS_RST) |-> OUT1_LS_DIV == $past(out1_code))
		else $error("Output 1 divider value does not follow its registers");

	out1_err_flag_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		REG_WR && hit_out1_low && !REG_WDATA[0] && out1_up_reg == 8'h00 && out1_mid_reg == 8'h00
		&& REG_WDATA != 8'h00 |=> ##1 OUT1_CFG_ERR)
		else $error("Even output 1 code not flagged");

	out2_assembly_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		REG_WR && hit_out2_mid |=> ##1 OUT2_LS_DIV[15:8] == $past(REG_WDATA, 2))
		else $error("Output 2 mid byte not reflected in divider");

	out2_err_flag_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		!$past(SYS_RST) |-> OUT2_CFG_ERR == ($past(out2_code) != 20'h0_0000 && !$past(out2_code[0])))
		else $error("Output 2 illegal code flag wrong");

	ls_ratio_code_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		!$past(SYS_RST) && $stable(OUT1_LS_DIV) |=> OUT1_RATIO == ((OUT1_LS_DIV == 20'h0_0000)
		? 21'h0_0001 : {1'b0, OUT1_LS_DIV} + 21'h0_0001))
		else $error("Output 1 ratio encoding wrong");

	fb_hs_ratio_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		REG_WR && hit_fb_up |=> ##1 FB_HS_DIV == $past(REG_WDATA[7:5], 2) ##1 FB_HS_RATIO == {1'b0, FB_HS_DIV} + 4'h4)
		else $error("Feedback high-speed ratio wrong");

	fb_ls_assembly_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		!$past(SYS_RST) |-> FB_LS_DIV == {$past(fb_up_reg[3:0]), $past(fb_mid_reg), $past(fb_low_reg)})
		else $error("Feedback low-speed value assembly wrong");

	fb_odd_flag_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		!$past(SYS_RST) |-> FB_CFG_ERR == !$past(fb_code[0]))
		else $error("Feedback even code flag wrong");

	reset_values_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		$fell(SYS_RST) |-> out1_low_reg == 8'h31 && out2_low_reg == 8'h31 && fb_up_reg == 8'hc0
		&& out1_up_reg == 8'h00 && out2_mid_reg == 8'h00 && fb_mid_reg == 8'h00)
		else $error("Register reset values wrong");

	fb_low_reset_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		$fell(SYS_RST) |-> fb_low_reg == 8'hf9 ##1 FB_LS_DIV[7:0] == $past(fb_low_reg))
		else $error("Feedback low byte reset or placement wrong");

	out_hs_ratio_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		!$past(SYS_RST) |-> OUT_HS_RATIO == {1'b0, $past(out_hs_code)} + 4'h4)
		else $error("Output high-speed ratio wrong");

	reserved_zero_a: assert property (@(posedge CLK) disable iff (SYS_RST)
		REG_RD && (hit_out1_up || hit_out2_up || hit_fb_up || hit_out_hs)
		|=> REG_RVALID && (REG_RDATA & ~$past(rsv_keep_mask)) == 8'h00)
		else $error("Reserved bits read back nonzero");

endmodule

/* sim/pdc_host.sv */
// Host model that drives the register byte port of the divider bank
module pdc_host
(
	input  wire logic       CLK,
	input  wire logic       REG_RVALID,
	input  wire logic [7:0] REG_RDATA,
	output logic            REG_WR,
	output logic            REG_RD,
	output logic      [7:0] REG_ADDR,
	output logic      [7:0] REG_WDATA
);
	timeunit 1ns;
	timeprecision 1ns;

	// Idle bus at time zero
	initial
	begin
		REG_WR = 1'b0;
		REG_RD = 1'b0;
		REG_ADDR = 8'h00;
		REG_WDATA = 8'h00;
	end

	// One-cycle write; released lines show the inverse so stale data never looks valid
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge CLK);
		REG_WR <= 1'b1;
		REG_ADDR <= a;
		REG_WDATA <= d;
		@(negedge CLK);
		REG_WR <= 1'b0;
		REG_ADDR <= ~a;
		REG_WDATA <= ~d;
	endtask

	// One-cycle read, answer awaited for a bounded number of cycles
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
		@(negedge CLK);
		REG_RD <= 1'b1;
		REG_ADDR <= a;
		@(negedge CLK);
		REG_RD <= 1'b0;
		REG_ADDR <= ~a;
		ok = 1'b0;
		d = 8'h00;
		for (int i = 0; i < 4 && !ok; i++)
		begin
			if (REG_RVALID === 1'b1)
			begin
				d = REG_RDATA;
				ok = 1'b1;
			end
			else
				@(negedge CLK);
		end
	endtask
endmodule

/* sim/test_pdc_regs.sv */
// Self-checking bench for the divider register bank
module test_pdc_regs;
	timeunit 1ns;
	timeprecision 1ns;

	logic        CLK;
	logic        SYS_RST;
	logic [7:0]  REG_ADDR, REG_WDATA, REG_RDATA;
	logic        REG_WR, REG_RD, REG_RVALID, OUT1_CFG_ERR, OUT2_CFG_ERR, FB_CFG_ERR;
	logic [19:0] OUT1_LS_DIV, OUT2_LS_DIV, FB_LS_DIV;
	logic [20:0] OUT1_RATIO, OUT2_RATIO, FB_LS_RATIO;
	logic [2:0]  OUT_HS_DIV, FB_HS_DIV;
	logic [3:0]  OUT_HS_RATIO, FB_HS_RATIO;
	int          failures = 0;
	int          check_count = 0;
	logic [31:0] seed = 32'h0001_6051;
	// Mapped offsets, reset values and writable masks, index aligned
	int adr[$] = '{8'h19, 8'h1f, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h28, 8'h29, 8'h2a};
	int rst[$] = '{8'h20, 8'h00, 8'h00, 8'h31, 8'h00, 8'h00, 8'h31, 8'hc0, 8'h00, 8'hf9};
	int msk[$] = '{8'he0, 8'h0f, 8'hff, 8'hff, 8'h0f, 8'hff, 8'hff, 8'hef, 8'hff, 8'hff};
	int mdl[$];

	pdc_regs u_dut (.CLK, .SYS_RST, .REG_ADDR, .REG_WR, .REG_RD, .REG_WDATA, .REG_RDATA, .REG_RVALID,
		.OUT1_LS_DIV, .OUT2_LS_DIV, .OUT1_RATIO, .OUT2_RATIO, .OUT_HS_DIV, .OUT_HS_RATIO, .FB_HS_DIV,
		.FB_HS_RATIO, .FB_LS_DIV, .FB_LS_RATIO, .OUT1_CFG_ERR, .OUT2_CFG_ERR, .FB_CFG_ERR);
	pdc_host u_host (.CLK, .REG_RVALID, .REG_RDATA, .REG_WR, .REG_RD, .REG_ADDR, .REG_WDATA);

	// Clock at 100 ns period
	initial
	begin
		CLK = 1'b0;
		forever #50 CLK = ~CLK;
	end

	// Fixed-seed xorshift for repeatable random traffic
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic results();
		if (failures == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e)
		begin
			failures++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	// Write through the host and mirror it in the model, reserved bits dropped
	task automatic mwr(input int i, input int d);
		u_host.wr(adr[i], d);
		mdl[i] = d & msk[i];
	endtask

	// Read back; a lost answer ends the run
	task automatic rchk(input int a, input int e);
		logic [7:0] d;
		bit         ok;
		u_host.rd(a, d, ok);
		if (!ok)
		begin
			failures++;
			results();
		end
		else
			chk(d, e);
	endtask

	// Outputs settle one cycle after the last register change; checked three cycles later
	task automatic ochk();
		int o1, o2, fb, hf, ho;
		repeat (3) @(negedge CLK);
		o1 = (mdl[1] & 15) << 16 | mdl[2] << 8 | mdl[3];
		o2 = (mdl[4] & 15) << 16 | mdl[5] << 8 | mdl[6];
		fb = (mdl[7] & 15) << 16 | mdl[8] << 8 | mdl[9];
		hf = mdl[7] >> 5;
		ho = mdl[0] >> 5;
		chk(OUT1_LS_DIV, o1);
		chk(OUT2_LS_DIV, o2);
		chk(OUT1_RATIO, o1 == 0 ? 1 : o1 + 1);
		chk(OUT2_RATIO, o2 == 0 ? 1 : o2 + 1);
		chk(OUT1_CFG_ERR, o1 != 0 && o1 % 2 == 0);
		chk(OUT2_CFG_ERR, o2 != 0 && o2 % 2 == 0);
		chk(FB_LS_DIV, fb);
		chk(FB_LS_RATIO, fb + 1);
		chk(FB_CFG_ERR, fb % 2 == 0);
		chk(FB_HS_DIV, hf);
		chk(FB_HS_RATIO, hf + 4);
		chk(OUT_HS_DIV, ho);
		chk(OUT_HS_RATIO, ho + 4);
	endtask

	// Reset held for n cycles, followed by a full read-back of the reset image
	task automatic reset_and_check(input int n);
		SYS_RST = 1'b1;
		repeat (n) @(negedge CLK);
		SYS_RST = 1'b0;
		mdl = rst;
		ochk();
		for (int i = 0; i < 10; i++)
			rchk(adr[i], rst[i]);
		rchk(8'h25, 8'h00);
	endtask

	// Main sequence
	initial
	begin
		int i;
		SYS_RST = 1'b1;
		reset_and_check(6);
		// All ones then all zeros: reserved bits must stay zero
		foreach (msk[p])
		begin
			if (p < 2)
			begin
				for (i = 0; i < 10; i++)
					mwr(i, p == 0 ? 8'hff : 8'h00);
				ochk();
				for (i = 0; i < 10; i++)
					rchk(adr[i], mdl[i]);
			end
		end
		// Unmapped write is ignored
		u_host.wr(8'h25, 8'hff);
		rchk(8'h25, 8'h00);
		// Even nonzero low bytes over cleared upper bytes: both output flags must rise
		mwr(3, 8'h44);
		mwr(6, 8'h12);
		ochk();
		// Every high-speed code, reserved bits set on the way in
		for (int c = 0; c < 8; c++)
		begin
			mwr(7, c << 5 | 8'h1f);
			mwr(0, c << 5 | 8'h1f);
			ochk();
		end
		// Random bytes, odd and even codes alike, into random registers
		repeat (40)
		begin
			i = int'(xs() % 10);
			mwr(i, int'(xs() & 32'h0000_00ff));
			if (i % 3 == 0)
				ochk();
			rchk(adr[i], mdl[i]);
		end
		ochk();
		reset_and_check(1);
		results();
	end
endmodule
